//--- pkg/sram_qualify_pkg.sv
// Constants and types for the synchronous burst SRAM write qualifier.
// Assumes a single rising-edge clock; all bus controls but the order strap are registered inside.
// Summary of operation
// - Write when global low or enable with lane.
// - Global write writes both lanes, except on a processor strobe, which reads.
// - Enabled means primary low, hi high, expand low.
// - Output enable ignored once write has begun.
// - Each lane select gates its own data lane.
// - Primary enable high blocks processor strobe only.
// - Burst advance steps two-bit counter in bursts.
// - Order input static: low linear, high interleaved.
package sram_qualify_pkg;

   //----------------------------------------------------------------
   // Widths
   //----------------------------------------------------------------
   localparam int ADDR_W  = 16;
   localparam int LANE_W  = 9;
   localparam int LANES   = 2;
   localparam int BURST_W = 2;

   //----------------------------------------------------------------
   // Reset values
   //----------------------------------------------------------------
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [LANES-1:0]   LANES_OFF = 2'h0;
   localparam logic [LANES-1:0]   LANES_ALL = 2'h3;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_READ,
      CYC_WRITE
   } cycle_t;

endpackage

//--- rtl/burst_counter.sv
// Two-bit burst address counter.
// Assumes the order input is a static strap and the controls come from registers.
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
   // Clock and reset
   input  wire logic                                 i_clock,
   input  wire logic                                 i_reset,
   // Control
   input  wire logic                                 i_load,
   input  wire logic [sram_qualify_pkg::BURST_W-1:0] i_load_value,
   input  wire logic                                 i_step,
   input  wire logic                                 i_burst_order_select,
   // Result
   output logic      [sram_qualify_pkg::BURST_W-1:0] o_offset
);
   import sram_qualify_pkg::*;

   logic [BURST_W-1:0] start_ff;
   logic [BURST_W-1:0] count_ff;
   logic [BURST_W-1:0] nxt_count;
   logic [BURST_W-1:0] used_count;

   // The order strap is used directly, never registered.
   // A step moves the address of the same cycle, so the stepped count is used at once.
   assign nxt_count  = count_ff + 2'h1;
   assign used_count = i_step ? nxt_count : count_ff;
   assign o_offset   = i_burst_order_select ? (start_ff ^ used_count)
                                            : (start_ff + used_count);

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         start_ff <= BURST_RST;
         count_ff <= BURST_RST;
      end else if (i_load) begin
         start_ff <= i_load_value;
         count_ff <= BURST_RST;
      end else if (i_step) begin
         count_ff <= nxt_count;
      end
   end
endmodule
`default_nettype wire

//--- rtl/sync_sram_write_qualify.sv
// Write qualification, chip-enable decode and burst addressing for a
// two-lane synchronous burst SRAM. Assumes a bus master on the same clock;
// the async output enable comes from outside and is synchronised; the data pins are captured in one register.
`timescale 1ns/1ps
`default_nettype none
module sync_sram_write_qualify (
   // Clock and reset
   input  wire logic                                   i_clock,
   input  wire logic                                   i_reset,
   // Bus controls
   input  wire logic                                   i_processor_addr_strobe_n,
   input  wire logic                                   i_controller_addr_strobe_n,
   input  wire logic                                   i_burst_advance_n,
   input  wire logic                                   i_chip_enable_primary_n,
   input  wire logic                                   i_chip_enable_expand_hi,
   input  wire logic                                   i_chip_enable_expand_n,
   input  wire logic                                   i_global_write_n,
   input  wire logic                                   i_lane_write_enable_n,
   input  wire logic                                   i_lane_a_select_n,
   input  wire logic                                   i_lane_b_select_n,
   input  wire logic                                   i_output_enable_n,
   input  wire logic                                   i_burst_order_select,
   input  wire logic [sram_qualify_pkg::ADDR_W-1:0]    i_address,
   // Data lanes
   input  wire logic [sram_qualify_pkg::LANE_W-1:0]    i_lane_a_data,
   input  wire logic [sram_qualify_pkg::LANE_W-1:0]    i_lane_b_data,
   output logic      [sram_qualify_pkg::LANE_W-1:0]    o_lane_a_data,
   output logic      [sram_qualify_pkg::LANE_W-1:0]    o_lane_b_data,
   output logic      [sram_qualify_pkg::LANES-1:0]     o_lane_data_oe,
   // Array side
   output logic      [sram_qualify_pkg::ADDR_W-1:0]    o_array_address,
   output logic      [sram_qualify_pkg::LANES-1:0]     o_lane_write_strobe,
   output logic      [2*sram_qualify_pkg::LANE_W-1:0]  o_array_write_data,
   output logic                                        o_array_read,
   // Status
   output logic                                        o_selected,
   output logic                                        o_write_cycle
);
   import sram_qualify_pkg::*;

   //----------------------------------------------------------------
   // Input registers
   //----------------------------------------------------------------
   // Every control but the order strap and the output enable is captured on the same edge as address and data.
   // The decode then works one edge later on these copies and the unregistered strap, which gives a
   // fixed latency of two edges from pin to output for every cycle type.
   // There is no reset on this stage: it is a plain pipeline and the cycle
   // state behind it is what reset holds idle.
   logic              pstrobe_n_ff, cstrobe_n_ff, advance_n_ff;
   logic              ce1_n_ff, ce2_ff, ce3_n_ff;
   logic              gw_n_ff, we_n_ff, sa_n_ff, sb_n_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [LANE_W-1:0] da_ff, db_ff;
   logic              oe_meta_ff, oe_n_ff;

   always_ff @(posedge i_clock) begin
      pstrobe_n_ff <= i_processor_addr_strobe_n;
      cstrobe_n_ff <= i_controller_addr_strobe_n;
      advance_n_ff <= i_burst_advance_n;
      ce1_n_ff  <= i_chip_enable_primary_n;
      ce2_ff    <= i_chip_enable_expand_hi;
      ce3_n_ff  <= i_chip_enable_expand_n;
      gw_n_ff   <= i_global_write_n;
      we_n_ff   <= i_lane_write_enable_n;
      sa_n_ff   <= i_lane_a_select_n;
      sb_n_ff   <= i_lane_b_select_n;
      addr_ff   <= i_address;
      da_ff     <= i_lane_a_data;
      db_ff     <= i_lane_b_data;
   end

   // The output enable is asynchronous, so it is brought in through two stages.
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         oe_meta_ff <= 1'b1;
         oe_n_ff    <= 1'b1;
      end else begin
         oe_meta_ff <= i_output_enable_n;
         oe_n_ff    <= oe_meta_ff;
      end
   end

   //----------------------------------------------------------------
   // Cycle decode
   //----------------------------------------------------------------
   logic             enabled;
   logic             pstrobe_taken;
   logic             new_cycle;
   logic             deselect;
   logic             is_write;
   logic [LANES-1:0] lane_sel;
   logic [LANES-1:0] nxt_strobe;
   logic             continuing;
   logic             step;
   logic [BURST_W-1:0] offset;
   cycle_t           cycle_ff;
   cycle_t           nxt_cycle;

   assign enabled    = !ce1_n_ff && ce2_ff && !ce3_n_ff;
   // A processor strobe with the primary enable high is dropped before it can
   // start or end anything; the controller strobe has no such escape.
   assign pstrobe_taken = !pstrobe_n_ff && !ce1_n_ff;
   assign new_cycle  = pstrobe_taken || (!cstrobe_n_ff && !pstrobe_taken);
   assign deselect   = new_cycle && !enabled;
   assign lane_sel   = {!sb_n_ff, !sa_n_ff};
   // A processor strobe that selects the device always starts a read; writes need the controller path
   // or a continuing cycle, matching how the strobe is intended to be used.
   assign is_write   = !gw_n_ff || (!we_n_ff && (lane_sel != LANES_OFF));
   assign continuing = !new_cycle && (cycle_ff != CYC_IDLE);
   assign step       = continuing && !advance_n_ff;

   always_comb begin
      nxt_cycle = cycle_ff;
      if (deselect) begin
         nxt_cycle = CYC_IDLE;
      end else if (pstrobe_taken) begin
         nxt_cycle = CYC_READ;
      end else if (new_cycle || continuing) begin
         nxt_cycle = is_write ? CYC_WRITE : CYC_READ;
      end
   end

   // Global write overrides the lane enable and the lane selects.
   assign nxt_strobe = (nxt_cycle != CYC_WRITE) ? LANES_OFF :
                       (!gw_n_ff ? LANES_ALL : lane_sel);

   burst_counter u_burst (
      .i_clock              (i_clock),
      .i_reset              (i_reset),
      .i_load               (new_cycle && enabled),
      .i_load_value         (addr_ff[BURST_W-1:0]),
      .i_step               (step),
      .i_burst_order_select (i_burst_order_select),
      .o_offset             (offset)
   );

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   logic [ADDR_W-1:0] base_ff;
   logic              drive_ok;
   logic [ADDR_W-1:0] nxt_address;

   always_ff @(posedge i_clock) begin
      if (new_cycle && enabled) begin
         base_ff <= addr_ff;
      end
   end

   // Drivers follow the cycle being entered, not the one being left, so the
   // first edge of a write already turns them off whatever the enable pin says.
   // The synchronised enable lags the pin by two edges; a master that lowers it
   // late sees the drivers come on two or three cycles after the pin.
   assign drive_ok = (nxt_cycle == CYC_READ) && !oe_n_ff;

   // A new cycle takes the pin address whole; afterwards only the two low
   // bits move, so a burst never leaves its aligned block of four words.
   assign nxt_address = (new_cycle && enabled) ? addr_ff :
                        {base_ff[ADDR_W-1:BURST_W], offset};

   //----------------------------------------------------------------
   // Cycle state and status
   //----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         cycle_ff      <= CYC_IDLE;
         o_array_read  <= 1'b0;
         o_selected    <= 1'b0;
         o_write_cycle <= 1'b0;
      end else begin
         cycle_ff      <= nxt_cycle;
         o_array_read  <= (nxt_cycle == CYC_READ);
         o_selected    <= (nxt_cycle != CYC_IDLE);
         o_write_cycle <= (nxt_cycle == CYC_WRITE);
      end
   end

   //----------------------------------------------------------------
   // Write path
   //----------------------------------------------------------------
   // Strobes and data leave on the same edge, so the array never sees a
   // strobe paired with the data of a neighbouring cycle.
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_lane_write_strobe <= LANES_OFF;
         o_array_write_data  <= '0;
      end else begin
         o_lane_write_strobe <= nxt_strobe;
         o_array_write_data  <= {db_ff, da_ff};
      end
   end

   //----------------------------------------------------------------
   // Array address
   //----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_array_address <= '0;
      end else begin
         o_array_address <= nxt_address;
      end
   end

   //----------------------------------------------------------------
   // Lane drivers
   //----------------------------------------------------------------
   // The lane outputs only echo the captured data; the array's own read data
   // is steered onto the pins outside this block.
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_lane_data_oe <= LANES_OFF;
         o_lane_a_data  <= '0;
         o_lane_b_data  <= '0;
      end else begin
         o_lane_data_oe <= drive_ok ? LANES_ALL : LANES_OFF;
         o_lane_a_data  <= da_ff;
         o_lane_b_data  <= db_ff;
      end
   end
endmodule
`default_nettype wire

//--- verif/sram_qualify_assertions.sv
// Concurrent checks on the ports of the SRAM write qualifier.
// Assumes outputs follow the pins by two rising edges of one clock.
`timescale 1ns/1ps
`default_nettype none
module sram_qualify_checker (
   // Clock, reset and strap
   input wire logic i_clock, i_reset, i_burst_order_select,
   // Bus controls
   input wire logic i_processor_addr_strobe_n, i_controller_addr_strobe_n, i_burst_advance_n,
   input wire logic i_chip_enable_primary_n, i_chip_enable_expand_hi, i_chip_enable_expand_n,
   input wire logic i_global_write_n, i_lane_write_enable_n, i_lane_a_select_n, i_lane_b_select_n,
   input wire logic [sram_qualify_pkg::LANE_W-1:0] i_lane_a_data, i_lane_b_data,
   // Design outputs
   input wire logic [sram_qualify_pkg::LANES-1:0] o_lane_data_oe, o_lane_write_strobe,
   input wire logic [sram_qualify_pkg::ADDR_W-1:0] o_array_address,
   input wire logic [2*sram_qualify_pkg::LANE_W-1:0] o_array_write_data,
   input wire logic o_selected, o_write_cycle
);
   import sram_qualify_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   chk_write_decode: assert property (o_write_cycle |-> !$past(i_global_write_n, 2)
      || !$past(i_lane_write_enable_n, 2) && !($past(i_lane_a_select_n, 2) && $past(i_lane_b_select_n, 2)))
      else $error("write cycle without a write control");
   chk_global_both: assert property (o_selected && !$past(i_global_write_n, 2)
      && $past(i_processor_addr_strobe_n, 2) |-> o_write_cycle && o_lane_write_strobe == LANES_ALL)
      else $error("global write did not hit both lanes");
   chk_lane_gate: assert property (o_write_cycle && $past(i_global_write_n, 2)
      |-> o_lane_write_strobe == {!$past(i_lane_b_select_n, 2), !$past(i_lane_a_select_n, 2)})
      else $error("lane strobes differ from lane selects");
   chk_enable_decode: assert property (!$past(i_controller_addr_strobe_n, 2)
      && $past(i_processor_addr_strobe_n, 2) |-> o_selected == (!$past(i_chip_enable_primary_n, 2)
      && $past(i_chip_enable_expand_hi, 2) && !$past(i_chip_enable_expand_n, 2))) else $error("bad select");
   chk_proc_blocked: assert property (!$past(i_processor_addr_strobe_n, 2)
      && $past(i_chip_enable_primary_n, 2) && $past(i_controller_addr_strobe_n, 2) |-> $stable(o_selected))
      else $error("blocked processor strobe changed selection");
   chk_oe_ignored: assert property (o_write_cycle |-> o_lane_data_oe == LANES_OFF)
      else $error("drivers on during write");
   chk_data_capture: assert property (o_write_cycle
      |-> o_array_write_data == {$past(i_lane_b_data, 2), $past(i_lane_a_data, 2)}) else $error("write data");
   chk_burst_upper: assert property (o_selected && $past(i_processor_addr_strobe_n, 2)
      && $past(i_controller_addr_strobe_n, 2) |-> (o_array_address >> 2) == ($past(o_array_address) >> 2))
      else $error("burst left its block");
   chk_linear_step: assert property (o_selected && $past(i_processor_addr_strobe_n, 2)
      && $past(i_controller_addr_strobe_n, 2) && !$past(i_burst_advance_n, 2) && !i_burst_order_select
      |-> o_array_address[1:0] == 2'($past(o_array_address) + 16'h1)) else $error("linear step");
endmodule
`default_nettype wire

//--- verif/bus_master_model.sv
// Bus master model: one cycle of the SRAM qualifier bus per call of op.
// Assumes op is entered just after a rising edge of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input wire logic i_clock,
   // Named after the device pins they drive, so the bench joins them by name.
   output logic i_processor_addr_strobe_n, i_controller_addr_strobe_n, i_burst_advance_n,
   output logic i_chip_enable_primary_n, i_chip_enable_expand_hi, i_chip_enable_expand_n,
   output logic i_global_write_n, i_lane_write_enable_n, i_lane_a_select_n, i_lane_b_select_n,
   output logic i_output_enable_n,
   output logic [sram_qualify_pkg::ADDR_W-1:0] i_address,
   output logic [sram_qualify_pkg::LANE_W-1:0] i_lane_a_data, i_lane_b_data
);
   import sram_qualify_pkg::*;
   // Released address and data lines invert, so a stale value is never mistaken for a fresh one.
   task automatic idle();
      {i_processor_addr_strobe_n, i_controller_addr_strobe_n, i_burst_advance_n} = 3'h7;
      {i_global_write_n, i_lane_write_enable_n} = 2'h3;
      {i_address, i_lane_b_data, i_lane_a_data} = ~{i_address, i_lane_b_data, i_lane_a_data};
   endtask
   task automatic op(input logic [1:0] st, input logic step_n, input logic [2:0] en, input logic [3:0] wr,
         input logic oe_n = 1'h1, input logic rude = 1'h0, input logic [ADDR_W-1:0] addr = 16'h0,
         input logic [2*LANE_W-1:0] data = 18'h0);
      {i_processor_addr_strobe_n, i_controller_addr_strobe_n, i_burst_advance_n} = {st, step_n};
      {i_chip_enable_primary_n, i_chip_enable_expand_hi, i_chip_enable_expand_n} = en;
      {i_global_write_n, i_lane_write_enable_n, i_lane_a_select_n, i_lane_b_select_n} = wr;
      i_output_enable_n = (!wr[3] || !wr[2] && !(wr[1] && wr[0])) && !rude ? 1'h1 : oe_n;
      {i_address, i_lane_b_data, i_lane_a_data} = {addr, data};
      @(posedge i_clock);
      #1;
      idle();
      @(posedge i_clock);
      #1;
   endtask
   initial begin
      {i_address, i_lane_b_data, i_lane_a_data} = 34'h0;
      {i_chip_enable_primary_n, i_chip_enable_expand_hi, i_chip_enable_expand_n} = 3'h5;
      {i_lane_a_select_n, i_lane_b_select_n, i_output_enable_n} = 3'h7;
      idle();
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the SRAM write qualifier, with master model and bound checker.
// Assumes package, design, model and checker are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sram_qualify_pkg::*;
   logic i_clock, i_reset, i_burst_order_select, o_array_read, o_selected, o_write_cycle, exp_write;
   logic i_processor_addr_strobe_n, i_controller_addr_strobe_n, i_burst_advance_n, i_output_enable_n;
   logic i_chip_enable_primary_n, i_chip_enable_expand_hi, i_chip_enable_expand_n;
   logic i_global_write_n, i_lane_write_enable_n, i_lane_a_select_n, i_lane_b_select_n;
   logic [ADDR_W-1:0] i_address, o_array_address;
   logic [LANE_W-1:0] i_lane_a_data, i_lane_b_data, o_lane_a_data, o_lane_b_data;
   logic [LANES-1:0] o_lane_data_oe, o_lane_write_strobe, exp_lanes;
   logic [2*LANE_W-1:0] o_array_write_data;
   int mismatches = 0;
   int total_checks = 0;
   sync_sram_write_qualify DUT (.*);
   bus_master_model master (.*);
   task automatic check(input logic [2*LANE_W-1:0] seen, input logic [2*LANE_W-1:0] expected);
      total_checks++;
      if (seen !== expected) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      i_clock = 1'h0;
      forever #4 i_clock = ~i_clock;
   end
   initial begin
      #5000;
      mismatches++;
      close_out();
   end
   initial begin
      {i_reset, i_burst_order_select} = 2'h2;
      repeat (5) @(posedge i_clock);
      #1;
      i_reset = 1'h0;
      check(o_selected, 1'h0);
      for (int i = 0; i < 16; i++) begin
         exp_write = !i[3] || !i[2] && !(i[1] && i[0]);
         exp_lanes = !i[3] ? LANES_ALL : i[2] ? LANES_OFF : {!i[0], !i[1]};
         master.op(2'h2, 1'h1, 3'h2, 4'(i), 1'h0, 1'h0, 16'(16'h4100 + i), 18'(18'h2A5C7 ^ i));
         check(o_write_cycle, exp_write);
         check(o_array_read, !exp_write);
         check({o_lane_b_data, o_lane_a_data}, 18'(18'h2A5C7 ^ i));
         check(o_lane_write_strobe, exp_lanes);
         if (exp_write) check(o_array_write_data, 18'(18'h2A5C7 ^ i));
      end
      // Output enable left low into a write by a careless master.
      master.op(2'h2, 1'h1, 3'h2, 4'hF, 1'h0);
      master.op(2'h3, 1'h1, 3'h2, 4'h0, 1'h0, 1'h1, 16'h0, 18'h1FF);
      check(o_write_cycle, 1'h1);
      check(o_lane_data_oe, LANES_OFF);
      for (int e = 0; e < 8; e++) begin
         master.op(2'h2, 1'h1, 3'(e), 4'hF);
         check(o_selected, e == 2);
      end
      master.op(2'h1, 1'h1, 3'h2, 4'hF);
      check(o_selected, 1'h1);
      master.op(2'h1, 1'h1, 3'h6, 4'hF);
      check(o_selected, 1'h1);
      master.op(2'h2, 1'h1, 3'h6, 4'hF);
      check(o_selected, 1'h0);
      for (int o = 0; o < 2; o++) begin
         i_burst_order_select = 1'(o);
         master.op(2'h2, 1'h1, 3'h2, 4'hF, 1'h1, 1'h0, 16'h1235);
         for (int k = 1; k < 4; k++) begin
            master.op(2'h3, 1'h0, 3'h2, 4'hF);
            check(o_array_address, {14'h048D, o ? 2'(1 ^ k) : 2'(1 + k)});
         end
      end
      close_out();
   end
endmodule
bind sync_sram_write_qualify sram_qualify_checker chk (.*);
`default_nettype wire
